// ---- rtl/wkf_pkg.sv ----
package wkf_pkg;
	localparam int NPIN = 5;
	localparam int NPUPD = 4;
	localparam int SYNC_PIN = 3;
	localparam int FO_PIN = 1;
	localparam int SREF_PIN = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PUPD = 8'h04;
	localparam logic [7:0] OFS_EVT = 8'h08;
	localparam logic [7:0] OFS_LVL = 8'h0C;
	localparam logic [7:0] OFS_DEV = 8'h10;
	// Wake control fields
	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_CYC = 5;
	localparam int CTRL_SYNC_LSB = 6;
	localparam int CTRL_FO = 8;
	localparam int CTRL_FILT_LSB = 9;
	localparam int CTRL_OVM_LSB = 12;
	localparam logic [4:0] EN_RST = 5'h00;
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam logic [2:0] FILT_RST = 3'h0;
	localparam logic [1:0] OVM_RST = 2'h0;
	localparam logic [7:0] PUPD_RST = 8'h00;
	localparam logic [1:0] SYNC_SEL = 2'h2;
	localparam logic [1:0] OVM_FAIL = 2'h3;
	localparam logic [2:0] FILT_LONG = 3'h1;
	localparam logic [2:0] FILT_SYNC = 3'h4;
	localparam logic [1:0] CS_DOWN = 2'h1;
	localparam logic [1:0] CS_UP = 2'h2;
	localparam logic [1:0] CS_AUTO = 2'h3;
	// Device status fields
	localparam int DEV_FAIL = 0;
	localparam int DEV_SPIF = 1;
	// Timing
	localparam int CLK_NS = 40;
	localparam int FILT1_NS = 16000;
	localparam int FILT2_NS = 64000;
	localparam int FILT1_CYC = FILT1_NS / CLK_NS;
	localparam int FILT2_CYC = FILT2_NS / CLK_NS;
	localparam logic [2:0] FAIL_CNT = 3'h4;

	typedef enum logic [2:0] {
		MODE_INIT = 3'b000,
		MODE_NORMAL = 3'b001,
		MODE_STOP = 3'b010,
		MODE_SLEEP = 3'b011,
		MODE_FAILSAFE = 3'b100
	} wkf_mode_e;

	typedef struct packed {
		logic wdFail;
		logic wdOk;
		logic thermal_shutdown_two;
		logic regShort;
		logic regOv;
		logic regUv;
		logic regUvOk;
	} wkf_fail_s;
endpackage

// ---- rtl/wkf_wake_failout.sv ----
`timescale 1ns/1ps
module wkf_wake_failout
	import wkf_pkg::*;
#(
	parameter int FILT_SHORT = FILT1_CYC,
	parameter int FILT_LONG_CYC = FILT2_CYC,
	parameter int CNT_W = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [NPIN-1:0] wakeCmp,
	input wire wkf_mode_e devMode,
	input wire logic hsOnTime,
	input wire logic sleepReq,
	input wire logic otherWakeSrc,
	input wire logic swReset,
	input wire wkf_fail_s failIn,
	output logic wakeIrq,
	output logic wakeUp,
	output logic sleepRefused,
	output logic sleepAccept,
	output logic failLowSide,
	output logic syncActive,
	output logic syncLevel,
	output logic [NPUPD-1:0] pullUpEn,
	output logic [NPUPD-1:0] pullDnEn
);
	if (FILT_SHORT < 2 || FILT_LONG_CYC < 2 || FILT_LONG_CYC >= (1 << CNT_W)
		|| FILT_SHORT >= (1 << CNT_W)) begin
		$error("wkf_wake_failout: filter counts do not fit the counter");
	end

	function automatic logic [CNT_W-1:0] filtLimit(input logic [2:0] sel);
		if (sel == FILT_LONG)
			return CNT_W'(FILT_LONG_CYC - 1);
		return CNT_W'(FILT_SHORT - 1);
	endfunction

	logic [NPIN-1:0] syncA_r, syncB_r, ref_r, evt_r, evtStat_r, lvl_r, pinAct;
	logic [CNT_W-1:0] cnt_r [NPIN];
	logic [NPIN-1:0] wakeEn_r;
	logic cyclic_r, foSel_r, lock_r, failure_r, spiFail_r, failCond, modeChg, refuse;
	logic [1:0] syncSel_r, ovMode_r;
	logic [2:0] filt_r, wdCnt_r, uvCnt_r;
	logic [7:0] pupd_r;
	wkf_mode_e prevMode_r;
	logic pend_r, wr_r, hreadyout_r, hresp_r, addrPh, doWr, doRd, ctrlReject;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r, rdData;
	logic wakeIrq_r, wakeUp_r, sleepRefused_r, sleepAccept_r, failLowSide_r;
	logic syncActive_r, syncLevel_r;
	logic [NPUPD-1:0] pullUp_r, pullDn_r;

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = hresp_r;
	assign wakeIrq = wakeIrq_r;
	assign wakeUp = wakeUp_r;
	assign sleepRefused = sleepRefused_r;
	assign sleepAccept = sleepAccept_r;
	assign failLowSide = failLowSide_r;
	assign syncActive = syncActive_r;
	assign syncLevel = syncLevel_r;
	assign pullUpEn = pullUp_r;
	assign pullDnEn = pullDn_r;

	// Bus slave: one wait state, data phase completes the cycle after
	assign addrPh = hsel && htrans[1] && hready;
	assign doWr = pend_r && wr_r;
	assign doRd = pend_r && !wr_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else if (pend_r) begin
			pend_r <= 1'b0;
			hreadyout_r <= 1'b1;
		end else if (addrPh) begin
			pend_r <= 1'b1;
			wr_r <= hwrite;
			addr_r <= {haddr[7:2], 2'b00};
			hreadyout_r <= 1'b0;
		end
	end

	always_comb begin
		rdData = 32'h0000_0000;
		if (addr_r == OFS_CTRL) begin
			rdData[CTRL_EN_LSB +: NPIN] = wakeEn_r;
			rdData[CTRL_CYC] = cyclic_r;
			rdData[CTRL_SYNC_LSB +: 2] = syncSel_r;
			rdData[CTRL_FO] = foSel_r;
			rdData[CTRL_FILT_LSB +: 3] = filt_r;
			rdData[CTRL_OVM_LSB +: 2] = ovMode_r;
		end else if (addr_r == OFS_PUPD) begin
			rdData[7:0] = pupd_r;
		end else if (addr_r == OFS_EVT) begin
			rdData[NPIN-1:0] = evtStat_r;
		end else if (addr_r == OFS_LVL) begin
			rdData[NPIN-1:0] = lvl_r;
		end else if (addr_r == OFS_DEV) begin
			rdData[DEV_FAIL] = failure_r;
			rdData[DEV_SPIF] = spiFail_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			hrdata_r <= 32'h0000_0000;
		else if (doRd)
			hrdata_r <= rdData;
	end

	assign ctrlReject = doWr && addr_r == OFS_CTRL && lock_r && hwdata[CTRL_FO] != foSel_r;

	// failout pin is fail output after reset
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			wakeEn_r <= EN_RST;
			cyclic_r <= 1'b0;
			syncSel_r <= SYNC_RST;
			foSel_r <= 1'b0;
			filt_r <= FILT_RST;
			ovMode_r <= OVM_RST;
			lock_r <= 1'b0;
			pupd_r <= PUPD_RST;
		end else begin
			if (doWr && addr_r == OFS_CTRL && !ctrlReject) begin
				wakeEn_r <= hwdata[CTRL_EN_LSB +: NPIN];
				cyclic_r <= hwdata[CTRL_CYC];
				syncSel_r <= hwdata[CTRL_SYNC_LSB +: 2];
				foSel_r <= hwdata[CTRL_FO];
				filt_r <= hwdata[CTRL_FILT_LSB +: 3];
				ovMode_r <= hwdata[CTRL_OVM_LSB +: 2];
				lock_r <= 1'b1;
			end
			if (doWr && addr_r == OFS_PUPD)
				pupd_r <= hwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			syncA_r <= '0;
			syncB_r <= '0;
		end else begin
			syncA_r <= wakeCmp;
			syncB_r <= syncA_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			prevMode_r <= MODE_INIT;
		else
			prevMode_r <= devMode;
	end

	assign modeChg = prevMode_r == MODE_INIT && devMode == MODE_NORMAL && !cyclic_r;

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			pinAct[i] = wakeEn_r[i];
			if (i == SYNC_PIN && syncSel_r == SYNC_SEL)
				pinAct[i] = 1'b0;
			if (i == FO_PIN && !foSel_r)
				pinAct[i] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			ref_r <= '0;
			evt_r <= '0;
			for (int i = 0; i < NPIN; i++)
				cnt_r[i] <= '0;
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				evt_r[i] <= 1'b0;
				if (!pinAct[i]) begin
					cnt_r[i] <= '0;
				// already active pin flagged on entry
				end else if (modeChg && syncB_r[i]) begin
					ref_r[i] <= 1'b1;
					evt_r[i] <= 1'b1;
					cnt_r[i] <= '0;
				// cyclic sense active only in on-time
				end else if (cyclic_r && !hsOnTime) begin
					cnt_r[i] <= '0;
				end else if (syncB_r[i] == ref_r[i]) begin
					cnt_r[i] <= '0;
				// same filter in both sense modes
				end else if (cnt_r[i] >= filtLimit(filt_r)) begin
					ref_r[i] <= syncB_r[i];
					evt_r[i] <= 1'b1;
					cnt_r[i] <= '0;
				end else begin
					cnt_r[i] <= cnt_r[i] + CNT_W'(1);
				end
			end
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge clk) begin
		if (rst || swReset)
			evtStat_r <= '0;
		else if (doWr && addr_r == OFS_EVT)
			evtStat_r <= (evtStat_r & ~hwdata[NPIN-1:0]) | evt_r;
		else
			evtStat_r <= evtStat_r | evt_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wakeIrq_r <= 1'b0;
			wakeUp_r <= 1'b0;
		end else begin
			wakeIrq_r <= |evt_r && (devMode == MODE_NORMAL || devMode == MODE_STOP);
			wakeUp_r <= |evt_r && (devMode == MODE_SLEEP || devMode == MODE_FAILSAFE);
		end
	end

	// present level, or last sample in cyclic sense
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_r <= '0;
		end else if (cyclic_r || devMode == MODE_INIT || devMode == MODE_NORMAL
			|| devMode == MODE_STOP) begin
			lvl_r <= cyclic_r ? ref_r : syncB_r;
			if (syncSel_r == SYNC_SEL)
				lvl_r[SYNC_PIN] <= 1'b0;
			if (!foSel_r)
				lvl_r[FO_PIN] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pullUp_r <= '0;
			pullDn_r <= '0;
		end else begin
			for (int i = 0; i < NPUPD; i++) begin
				pullUp_r[i] <= pupd_r[2*i +: 2] == CS_UP
					|| (pupd_r[2*i +: 2] == CS_AUTO && ref_r[i]);
				pullDn_r[i] <= pupd_r[2*i +: 2] == CS_DOWN
					|| (pupd_r[2*i +: 2] == CS_AUTO && !ref_r[i]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			syncActive_r <= 1'b0;
			syncLevel_r <= 1'b0;
		end else begin
			syncActive_r <= syncSel_r == SYNC_SEL;
			syncLevel_r <= syncSel_r == SYNC_SEL && syncB_r[SYNC_PIN];
		end
	end

	// sleep with only sync-driven cyclic source
	assign refuse = cyclic_r && filt_r == FILT_SYNC && !otherWakeSrc;

	always_ff @(posedge clk) begin
		if (rst) begin
			sleepRefused_r <= 1'b0;
			sleepAccept_r <= 1'b0;
		end else begin
			sleepRefused_r <= sleepReq && refuse;
			sleepAccept_r <= sleepReq && !refuse;
		end
	end

	// good trigger ends the watchdog count
	always_ff @(posedge clk) begin
		if (rst) begin
			wdCnt_r <= 3'h0;
			uvCnt_r <= 3'h0;
		end else begin
			if (failIn.wdOk)
				wdCnt_r <= 3'h0;
			else if (failIn.wdFail && wdCnt_r != FAIL_CNT)
				wdCnt_r <= wdCnt_r + 3'h1;
			if (failIn.regUvOk)
				uvCnt_r <= 3'h0;
			else if (failIn.regUv && uvCnt_r != FAIL_CNT)
				uvCnt_r <= uvCnt_r + 3'h1;
		end
	end

	assign failCond = wdCnt_r == FAIL_CNT || failIn.thermal_shutdown_two || failIn.regShort
		|| (failIn.regOv && ovMode_r == OVM_FAIL) || uvCnt_r == FAIL_CNT;

	// clear ignored while a condition stands
	always_ff @(posedge clk) begin
		if (rst || swReset) begin
			failure_r <= 1'b0;
			spiFail_r <= 1'b0;
		end else begin
			if (doWr && addr_r == OFS_DEV)
				failure_r <= failCond || (failure_r && !hwdata[DEV_FAIL]);
			else
				failure_r <= failCond || failure_r;
			if (ctrlReject)
				spiFail_r <= 1'b1;
			else if (doWr && addr_r == OFS_DEV && hwdata[DEV_SPIF])
				spiFail_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			failLowSide_r <= 1'b0;
		else
			failLowSide_r <= failure_r && !foSel_r;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_evt_stat: assert property (|evt_r && !swReset
		|=> (evtStat_r & $past(evt_r)) == $past(evt_r))
		else $error("event did not set status");
	chk_irq_mode: assert property (wakeIrq |-> $past(devMode) inside {MODE_NORMAL, MODE_STOP})
		else $error("interrupt outside Normal or Stop");
	chk_wake_mode: assert property (|evt_r && devMode == MODE_SLEEP |=> wakeUp && !wakeIrq)
		else $error("no wake-up in Sleep");
	chk_fail_on: assert property (failCond && !foSel_r && !swReset
		##1 !swReset |=> failLowSide)
		else $error("fail output not on");
	chk_fail_hold: assert property (failure_r && failCond && !swReset |=> failure_r)
		else $error("failure flag cleared under condition");
	chk_lock_reject: assert property (ctrlReject && !swReset
		|=> spiFail_r && foSel_r == $past(foSel_r))
		else $error("locked select changed");
	chk_sync_nowake: assert property (syncSel_r == SYNC_SEL |=> !evt_r[SYNC_PIN])
		else $error("sync pin produced wake event");
	chk_sleep_refuse: assert property (sleepReq && refuse |=> sleepRefused && !sleepAccept)
		else $error("sleep not refused");
	chk_pupd_decode: assert property (pupd_r[1:0] == CS_DOWN && !swReset
		|=> pullDnEn[0] && !pullUpEn[0])
		else $error("pull-down decode wrong");
	chk_filter_hold: assert property (pinAct[0] && !cyclic_r && !modeChg
		&& syncB_r[0] != ref_r[0] && cnt_r[0] == '0 && !swReset |=> !evt_r[0])
		else $error("event before filter time");

	cov_wake_irq: cover property (wakeIrq);
	cov_wake_up: cover property (wakeUp);
	cov_fail_cycle: cover property ($fell(failLowSide));
	cov_lock_reject: cover property (ctrlReject);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
	import wkf_pkg::*;
;
	localparam int FS = 4;
	localparam int FL = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic sleepReq = 1'b0;
	logic otherWakeSrc = 1'b0;
	logic swReset = 1'b0;
	logic hsOnTime = 1'b1;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [1:0] htrans = '0;
	logic hreadyout, hresp, wakeIrq, wakeUp, sleepRefused, sleepAccept;
	logic failLowSide, syncActive, syncLevel;
	logic [NPUPD-1:0] pullUpEn, pullDnEn;
	logic [NPIN-1:0] wakeCmp;
	wkf_mode_e devMode = MODE_INIT;
	wkf_fail_s failIn = '0;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int irqCnt = 0;
	int wakeCnt = 0;
	int refCnt = 0;
	int accCnt = 0;

	wkf_wake_failout #(.FILT_SHORT(FS), .FILT_LONG_CYC(FL)) wkf_wake_failout_inst (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wakeCmp(wakeCmp),
		.devMode(devMode), .hsOnTime(hsOnTime), .sleepReq(sleepReq),
		.otherWakeSrc(otherWakeSrc), .swReset(swReset), .failIn(failIn),
		.wakeIrq(wakeIrq), .wakeUp(wakeUp), .sleepRefused(sleepRefused),
		.sleepAccept(sleepAccept), .failLowSide(failLowSide), .syncActive(syncActive),
		.syncLevel(syncLevel), .pullUpEn(pullUpEn), .pullDnEn(pullDnEn)
	);
	wkf_switch_model wkf_switch_model_inst (.clk(clk), .wakeCmp(wakeCmp));

	initial begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		irqCnt <= irqCnt + int'(wakeIrq === 1'b1);
		wakeCnt <= wakeCnt + int'(wakeUp === 1'b1);
		refCnt <= refCnt + int'(sleepRefused === 1'b1);
		accCnt <= accCnt + int'(sleepAccept === 1'b1);
	end

	task automatic tally_and_finish();
		$display("Comparisons %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Single word transfer, waits on hready in both phases
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), e, q);
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			@(posedge clk);
			failIn[b] <= 1'b1;
			@(posedge clk);
			failIn[b] <= 1'b0;
		end
		waitc(3);
	endtask
	// Level condition: switch on, clear refused while present, off once gone
	task automatic failLevel(input int b);
		@(posedge clk);
		failIn[b] <= 1'b1;
		waitc(4);
		chk("failLowSide", 32'h1, 32'(failLowSide));
		wr(OFS_DEV, 32'h1);
		rd(OFS_DEV, 32'h1);
		@(posedge clk);
		failIn[b] <= 1'b0;
		wr(OFS_DEV, 32'h1);
		waitc(3);
		chk("failLowSide", 32'h0, 32'(failLowSide));
	endtask
	task automatic sleepPulse();
		@(posedge clk);
		sleepReq <= 1'b1;
		@(posedge clk);
		sleepReq <= 1'b0;
		waitc(3);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_PUPD, 32'h0);
		rd(OFS_EVT, 32'h0);
		rd(8'h14, 32'h0);
		wr(OFS_CTRL, 32'h11F);
		rd(OFS_CTRL, 32'h11F);
		wr(OFS_CTRL, 32'h1F);
		rd(OFS_CTRL, 32'h11F);
		rd(OFS_DEV, 32'h2);
		wr(OFS_DEV, 32'h2);
		rd(OFS_DEV, 32'h0);
		wr(OFS_PUPD, 32'hE4);
		waitc(4);
		chk("pull", 32'h4A, 32'({pullUpEn, pullDnEn}));
		wkf_switch_model_inst.setPin(0, 1'b1);
		waitc(14);
		@(posedge clk);
		devMode <= MODE_NORMAL;
		waitc(6);
		chk("irq", 32'h1, 32'(irqCnt));
		rd(OFS_EVT, 32'h1);
		rd(OFS_LVL, 32'h1);
		wr(OFS_EVT, 32'h1F);
		wkf_switch_model_inst.bounce(0, 2);
		waitc(14);
		rd(OFS_EVT, 32'h0);
		wkf_switch_model_inst.setPin(0, 1'b0);
		waitc(14);
		rd(OFS_EVT, 32'h1);
		wr(OFS_EVT, 32'h1F);
		wr(OFS_CTRL, 32'h31E);
		wkf_switch_model_inst.setPin(0, 1'b1);
		wkf_switch_model_inst.bounce(1, 6);
		waitc(20);
		rd(OFS_EVT, 32'h0);
		wkf_switch_model_inst.setPin(1, 1'b1);
		waitc(20);
		rd(OFS_EVT, 32'h2);
		wkf_switch_model_inst.setPin(3, 1'b1);
		waitc(14);
		chk("pull", 32'hC2, 32'({pullUpEn, pullDnEn}));
		wr(OFS_EVT, 32'h1F);
		@(posedge clk);
		devMode <= MODE_SLEEP;
		wkf_switch_model_inst.setPin(2, 1'b1);
		waitc(20);
		chk("wakeUp", 32'h1, 32'(wakeCnt));
		chk("irq", 32'h4, 32'(irqCnt));
		@(posedge clk);
		devMode <= MODE_NORMAL;
		wr(OFS_CTRL, 32'h39E);
		wr(OFS_EVT, 32'h1F);
		wkf_switch_model_inst.setPin(3, 1'b0);
		waitc(14);
		chk("syncActive", 32'h1, 32'(syncActive));
		rd(OFS_EVT, 32'h0);
		wkf_switch_model_inst.setPin(3, 1'b1);
		waitc(4);
		chk("syncLevel", 32'h1, 32'(syncLevel));
		rd(OFS_EVT, 32'h0);
		rd(OFS_LVL, 32'h7);
		wr(OFS_CTRL, 32'h93E);
		sleepPulse();
		chk("refused", 32'h1, 32'(refCnt));
		otherWakeSrc <= 1'b1;
		sleepPulse();
		chk("accepted", 32'h1, 32'(accCnt));
		@(posedge clk);
		swReset <= 1'b1;
		@(posedge clk);
		swReset <= 1'b0;
		rd(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h0);
		@(posedge clk);
		failIn.regOv <= 1'b1;
		waitc(4);
		chk("failLowSide", 32'h0, 32'(failLowSide));
		failIn.regOv <= 1'b0;
		wr(OFS_DEV, 32'h1);
		wr(OFS_CTRL, 32'h3000);
		failLevel(2);
		failLevel(4);
		failLevel(3);
		pulse(6, 3);
		chk("failLowSide", 32'h0, 32'(failLowSide));
		pulse(6, 1);
		chk("failLowSide", 32'h1, 32'(failLowSide));
		wr(OFS_DEV, 32'h1);
		waitc(3);
		chk("failLowSide", 32'h1, 32'(failLowSide));
		pulse(5, 1);
		wr(OFS_DEV, 32'h1);
		waitc(3);
		chk("failLowSide", 32'h0, 32'(failLowSide));
		pulse(1, 4);
		chk("failLowSide", 32'h1, 32'(failLowSide));
		pulse(0, 1);
		wr(OFS_DEV, 32'h1);
		waitc(3);
		chk("failLowSide", 32'h0, 32'(failLowSide));
		tally_and_finish();
	end
endmodule

// ---- test/wkf_switch_model.sv ----
`timescale 1ns/1ps
module wkf_switch_model
	import wkf_pkg::*;
(
	input wire logic clk,
	output logic [NPIN-1:0] wakeCmp
);
	// Contacts start closed to ground
	initial wakeCmp = '0;
	task automatic setPin(input int p, input logic v);
		@(posedge clk);
		wakeCmp[p] <= v;
	endtask
	// Contact bounce: opposite level for n cycles, then back
	task automatic bounce(input int p, input int n);
		@(posedge clk);
		wakeCmp[p] <= ~wakeCmp[p];
		repeat (n) @(posedge clk);
		wakeCmp[p] <= ~wakeCmp[p];
	endtask
endmodule
